//--- include/motor_startup_pkg.sv
`default_nettype none

package motor_startup_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] STARTUP_BRAKE_CONFIG_ADDR = 8'h92;
  localparam logic [7:0] STARTUP_ACCEL_CONFIG_ADDR = 8'h93;
  localparam logic [15:0] STARTUP_BRAKE_CONFIG_RESET = 16'h0000;
  localparam logic [15:0] STARTUP_ACCEL_CONFIG_RESET = 16'h0000;
  // Bit 15 of the acceleration register is reserved and reads zero
  localparam logic [15:0] ACCEL_WRITE_MASK = 16'h7FFF;

  // ==========================================================
  // Field positions (LSB of each field)
  // ==========================================================
  localparam int STATIONARY_THR_LSB = 14;
  localparam int BRAKE_CUR_SEL_BIT = 13;
  localparam int HYSTERESIS_BIT = 12;
  localparam int SPEED_DETECT_EN_BIT = 11;
  localparam int REVERSE_EN_BIT = 10;
  localparam int REVERSE_THR_LSB = 8;
  localparam int CURRENT_LSB = 6;
  localparam int RAMP_LSB = 3;
  localparam int BRAKE_TIME_LSB = 0;
  localparam int ACCEL_RANGE_BIT = 14;
  localparam int ACCEL2_LSB = 11;
  localparam int ACCEL1_LSB = 8;
  localparam int HANDOVER_LSB = 3;
  localparam int ALIGN_TIME_LSB = 0;

  // ==========================================================
  // Timing: clock period and derived cycles per millisecond
  // ==========================================================
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PS_PER_MS = 1000000000;
  localparam int CYCLES_PER_MS = PS_PER_MS / CLK_PERIOD_PS;

  // ==========================================================
  // Decode tables, indexed by field code, and hand-over step and base constants
  // ==========================================================
  // Stationary window in ms
  localparam logic [15:0] STATIONARY_WINDOW_MS [4] =
    '{16'h0050, 16'h00A0, 16'h0140, 16'h0280};
  // Brake done time in ms, code 0 means braking off
  localparam logic [15:0] BRAKE_TIME_MS [8] = '{16'h0000, 16'h0A8C,
    16'h0514, 16'h029E, 16'h014A, 16'h00A0, 16'h0050, 16'h0028};
  // Align hold time in ms
  localparam logic [15:0] ALIGN_TIME_MS [8] = '{16'h14B4, 16'h0A8C,
    16'h0514, 16'h029E, 16'h014A, 16'h00A0, 16'h0050, 16'h0028};
  // Reverse/brake speed threshold in 0.1 Hz
  localparam logic [11:0] REVERSE_THR_DHZ [4] =
    '{12'h03F, 12'h082, 12'h104, 12'h1FE};
  localparam logic [5:0] BRAKE_CUR_MA [2] = '{6'h18, 6'h30};
  localparam logic [5:0] HYSTERESIS_MV [2] = '{6'h14, 6'h28};
  localparam logic [10:0] OPEN_LOOP_CURR_MA [4] =
    '{11'h0C8, 11'h190, 11'h320, 11'h640};
  localparam logic [10:0] ALIGN_CURR_MA [4] =
    '{11'h096, 11'h12C, 11'h258, 11'h4B0};
  // Ramp rate in thousandths of supply voltage per second
  localparam logic [12:0] RAMP_MVCC [8] = '{13'h1770, 13'h0BB8,
    13'h05DC, 13'h02BC, 13'h0154, 13'h00A0, 13'h0046, 13'h0017};
  // Second-order acceleration in 0.0001 Hz/s^2
  localparam logic [19:0] ACCEL2_FAST [8] = '{20'h8B290, 20'h46CD0,
    20'h222E0, 20'h10D88, 20'h080E8, 20'h03E80, 20'h019C8, 20'h00000};
  localparam logic [19:0] ACCEL2_SLOW [8] = '{20'h00898, 20'h0044C,
    20'h00226, 20'h0010E, 20'h00082, 20'h0003F, 20'h0001B, 20'h00000};
  // First-order acceleration in mHz/s
  localparam logic [16:0] ACCEL1_FAST [8] = '{17'h128E0, 17'h09470,
    17'h04A38, 17'h023F0, 17'h01194, 17'h00834, 17'h00384, 17'h0012C};
  localparam logic [16:0] ACCEL1_SLOW [8] = '{17'h012C0, 17'h00960,
    17'h004B0, 17'h00244, 17'h0010E, 17'h00082, 17'h00038, 17'h00013};
  // Hand-over threshold in 0.1 Hz: low range step, high range step/base
  localparam logic [11:0] HANDOVER_STEP_LOW = 12'h008;
  localparam logic [11:0] HANDOVER_STEP_HIGH = 12'h080;
  localparam logic [11:0] HANDOVER_BASE_HIGH = 12'h077;

endpackage

`default_nettype wire

//--- hdl/motor_startup_brake_config.sv
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Stationary when no zero cross in window
// - Brake current threshold 24 or 48 mA
// - Comparator hysteresis 20 or 40 mV
// - Speed detection runs only when enabled
// - Reverse drive only when enabled
// - Reverse or brake once speed reaches threshold
// - Open-loop current 0.2 to 1.6 A
// - Align current 0.15 to 1.2 A
// - Ramp rate falls per code, 6000 down to 23 thousandths of supply per second
// - Brake code zero disables, else timed
// - Range bit picks fast or slow table
// - Second-order acceleration table, code seven zero
// - First-order acceleration table per range
// - Low hand-over range is n times 0.8 Hz
// - High hand-over range 12.8(n-16)+11.9 Hz
// - Align time 5.3 s down to 0.04 s
// - Both registers reset to zero
module motor_startup_brake_config #(
  parameter int CYCLES_PER_MS = motor_startup_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [15:0] regWriteData,
  input wire logic regRead,
  output logic [15:0] regReadData,
  // Sequence requests and motor observations
  input wire logic startReq,
  input wire logic brakeReq,
  input wire logic zeroCross,
  input wire logic wrongDirection,
  input wire logic [11:0] speedDhz,
  // Sequence status
  output logic isdActive,
  output logic motorStationary,
  output logic reverseStart,
  output logic alignActive,
  output logic alignDone,
  output logic brakeActive,
  output logic brakeDone,
  // Decoded drive settings
  output logic [5:0] brakeCurrentMa,
  output logic [5:0] hysteresisMv,
  output logic [10:0] openLoopCurrentMa,
  output logic [10:0] alignCurrentMa,
  output logic [12:0] rampRateMvcc,
  output logic [19:0] accel2Value,
  output logic [16:0] accel1Value,
  output logic [11:0] handoverDhz,
  output logic handoverValid
);
  import motor_startup_pkg::*;

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  localparam int TICK_W = $clog2(CYCLES_PER_MS + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYCLES_PER_MS - 1);
  generate
    if (CYCLES_PER_MS < 1)
    begin : g_bad_rate
      $error("CYCLES_PER_MS must be at least one");
    end
  endgenerate

  // ==========================================================
  // Reset release synchroniser
  // ==========================================================
  logic rstMeta_r; // First stage, read only by second
  logic rstSync_n; // Released reset for the whole block
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  // ==========================================================
  // Software registers
  // ==========================================================
  logic [15:0] brakeCfg_r; // Written copy, startup and brake
  logic [15:0] accelCfg_r; // Written copy, acceleration
  logic [15:0] actBrakeCfg_r; // Copy in force for current sequence
  logic [15:0] actAccelCfg_r;
  wire hitBrake = (regAddr == STARTUP_BRAKE_CONFIG_ADDR);
  wire hitAccel = (regAddr == STARTUP_ACCEL_CONFIG_ADDR);
  // Unmapped reads return zero
  wire [15:0] readMux = hitBrake ? brakeCfg_r :
    (hitAccel ? accelCfg_r : 16'h0000);

  // Writes land in the written copy only
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      brakeCfg_r <= STARTUP_BRAKE_CONFIG_RESET;
      accelCfg_r <= STARTUP_ACCEL_CONFIG_RESET;
    end
    else if (regWrite)
    begin
      if (hitBrake)
        brakeCfg_r <= regWriteData;
      // Reserved bit is dropped so it keeps reading zero
      if (hitAccel)
        accelCfg_r <= regWriteData & ACCEL_WRITE_MASK;
    end
  end

  // Read data is held between reads
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      regReadData <= 16'h0000;
    else if (regRead)
      regReadData <= readMux;
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DETECT = 2'b01,
    ST_ALIGN = 2'b10,
    ST_BRAKE = 2'b11
  } seq_state_e;
  seq_state_e state_r;
  seq_state_e state_nxt;
  logic [TICK_W-1:0] tickCnt_r; // Cycles within current ms
  logic [15:0] msCnt_r; // Whole ms elapsed in state

  wire idle = (state_r == ST_IDLE);
  // A request is only taken from idle, so settings can't shift mid-run
  wire takeStart = idle && startReq;
  wire takeBrakeCode = idle && !startReq && brakeReq;
  wire [2:0] brakeCodeW = brakeCfg_r[BRAKE_TIME_LSB +: 3];
  wire takeBrake = takeBrakeCode && (brakeCodeW != 3'h0);
  wire latchCfg = takeStart || takeBrake;

  // Limits come from the settings in force
  wire [2:0] brakeCode = actBrakeCfg_r[BRAKE_TIME_LSB +: 3];
  wire brakeOn = (brakeCode != 3'h0);
  wire [15:0] windowMs =
    STATIONARY_WINDOW_MS[actBrakeCfg_r[STATIONARY_THR_LSB +: 2]];
  wire [15:0] alignMs =
    ALIGN_TIME_MS[actAccelCfg_r[ALIGN_TIME_LSB +: 3]];
  wire [15:0] brakeMs = BRAKE_TIME_MS[brakeCode];
  wire [15:0] limitMs = (state_r == ST_DETECT) ? windowMs :
    ((state_r == ST_ALIGN) ? alignMs : brakeMs);
  wire tick = (tickCnt_r == TICK_LAST);
  wire elapsed = tick && ((msCnt_r + 16'h0001) == limitMs);
  wire [11:0] revThr =
    REVERSE_THR_DHZ[actBrakeCfg_r[REVERSE_THR_LSB +: 2]];
  wire slowEnough = wrongDirection && (speedDhz <= revThr);
  wire revEn = actBrakeCfg_r[REVERSE_EN_BIT];
  // A zero cross restarts the stationary window
  wire restartTimer = (state_r != state_nxt) ||
    ((state_r == ST_DETECT) && zeroCross);

  // Next state selection
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (takeStart)
          state_nxt = brakeCfg_r[SPEED_DETECT_EN_BIT] ? ST_DETECT :
            ST_ALIGN;
        else if (takeBrake)
          state_nxt = ST_BRAKE;
      ST_DETECT:
        // Wrong-way motor slowed to threshold: reverse or brake
        if (slowEnough && revEn)
          state_nxt = ST_IDLE;
        else if (slowEnough && brakeOn)
          state_nxt = ST_BRAKE;
        else if (elapsed && !zeroCross)
          state_nxt = ST_ALIGN;
      ST_ALIGN:
        if (elapsed)
          state_nxt = ST_IDLE;
      ST_BRAKE:
        if (elapsed)
          state_nxt = ST_IDLE;
    endcase
  end

  // State and active settings
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      state_r <= ST_IDLE;
      actBrakeCfg_r <= STARTUP_BRAKE_CONFIG_RESET;
      actAccelCfg_r <= STARTUP_ACCEL_CONFIG_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      if (latchCfg)
      begin
        actBrakeCfg_r <= brakeCfg_r;
        actAccelCfg_r <= accelCfg_r;
      end
    end
  end

  // Millisecond timer, restarted on each state change
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      tickCnt_r <= '0;
      msCnt_r <= 16'h0000;
    end
    else if (restartTimer)
    begin
      tickCnt_r <= '0;
      msCnt_r <= 16'h0000;
    end
    else if (tick)
    begin
      tickCnt_r <= '0;
      msCnt_r <= msCnt_r + 16'h0001;
    end
    else
      tickCnt_r <= tickCnt_r + TICK_W'(1);
  end

  // ==========================================================
  // Decoded settings, all from the copy in force
  // ==========================================================
  wire slowRange = actAccelCfg_r[ACCEL_RANGE_BIT];
  wire [2:0] acc2Code = actAccelCfg_r[ACCEL2_LSB +: 3];
  wire [2:0] acc1Code = actAccelCfg_r[ACCEL1_LSB +: 3];
  wire [4:0] hoCode = actAccelCfg_r[HANDOVER_LSB +: 5];
  wire [11:0] hoLow = HANDOVER_STEP_LOW * {8'h00, hoCode[3:0]};
  wire [11:0] hoHigh = HANDOVER_STEP_HIGH * {8'h00, hoCode[3:0]}
    + HANDOVER_BASE_HIGH;
  wire [1:0] curCode = actBrakeCfg_r[CURRENT_LSB +: 2];

  // Status and settings outputs
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      isdActive <= 1'b0;
      motorStationary <= 1'b0;
      reverseStart <= 1'b0;
      alignActive <= 1'b0;
      alignDone <= 1'b0;
      brakeActive <= 1'b0;
      brakeDone <= 1'b0;
      brakeCurrentMa <= BRAKE_CUR_MA[0];
      hysteresisMv <= HYSTERESIS_MV[0];
      openLoopCurrentMa <= OPEN_LOOP_CURR_MA[0];
      alignCurrentMa <= ALIGN_CURR_MA[0];
      rampRateMvcc <= RAMP_MVCC[0];
      accel2Value <= ACCEL2_FAST[0];
      accel1Value <= ACCEL1_FAST[0];
      handoverDhz <= 12'h000;
      handoverValid <= 1'b0;
    end
    else
    begin
      isdActive <= (state_nxt == ST_DETECT);
      alignActive <= (state_nxt == ST_ALIGN);
      brakeActive <= (state_nxt == ST_BRAKE);
      motorStationary <= (state_r == ST_DETECT) &&
        (state_nxt == ST_ALIGN);
      reverseStart <= (state_r == ST_DETECT) && slowEnough &&
        revEn;
      alignDone <= (state_r == ST_ALIGN) && elapsed;
      brakeDone <= (state_r == ST_BRAKE) && elapsed;
      brakeCurrentMa <=
        BRAKE_CUR_MA[actBrakeCfg_r[BRAKE_CUR_SEL_BIT]];
      hysteresisMv <= HYSTERESIS_MV[actBrakeCfg_r[HYSTERESIS_BIT]];
      openLoopCurrentMa <= OPEN_LOOP_CURR_MA[curCode];
      alignCurrentMa <= ALIGN_CURR_MA[curCode];
      rampRateMvcc <= RAMP_MVCC[actBrakeCfg_r[RAMP_LSB +: 3]];
      accel2Value <= slowRange ? ACCEL2_SLOW[acc2Code] :
        ACCEL2_FAST[acc2Code];
      accel1Value <= slowRange ? ACCEL1_SLOW[acc1Code] :
        ACCEL1_FAST[acc1Code];
      // Code 0 0000 has no meaning; it shows as not valid
      handoverDhz <= hoCode[4] ? hoHigh : hoLow;
      handoverValid <= (hoCode != 5'h00);
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  a_stationary_window: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    motorStationary |-> !$past(zeroCross) &&
      ($past(msCnt_r) + 16'h0001 == $past(windowMs)))
    else $error("stationary reported off its window");

  a_brake_current: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    $stable(actBrakeCfg_r) |=> brakeCurrentMa ==
      ($past(actBrakeCfg_r[BRAKE_CUR_SEL_BIT]) ? 6'h30 : 6'h18))
    else $error("brake current level wrong");

  a_hyst_level: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    $stable(actBrakeCfg_r) |=> hysteresisMv ==
      ($past(actBrakeCfg_r[HYSTERESIS_BIT]) ? 6'h28 : 6'h14))
    else $error("hysteresis level wrong");

  a_detect_skip: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    idle && startReq && !brakeCfg_r[SPEED_DETECT_EN_BIT]
      |=> alignActive && !isdActive)
    else $error("speed detection not skipped");

  a_reverse_gate: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    reverseStart |-> $past(revEn) && $past(speedDhz <= revThr))
    else $error("reverse started without enable");

  a_brake_off: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    idle && brakeReq && !startReq && brakeCodeW == 3'h0
      |=> !brakeActive [*2])
    else $error("brake ran with braking off");

  a_align_length: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    alignDone |-> $past(msCnt_r) + 16'h0001 ==
      ALIGN_TIME_MS[$past(actAccelCfg_r[ALIGN_TIME_LSB +: 3])])
    else $error("align time wrong");

  a_reserved_zero: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    regRead && hitAccel |=> regReadData[15] == 1'b0)
    else $error("reserved bit read as one");

  a_reset_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    rstSync_n && !$past(rstSync_n) |->
      brakeCfg_r == 16'h0000 && accelCfg_r == 16'h0000)
    else $error("registers not zero after reset");

  a_config_hold: assert property (
    @(posedge clk) disable iff (!rstSync_n)
    !idle |=> $stable(actBrakeCfg_r) && $stable(actAccelCfg_r))
    else $error("settings changed mid-sequence");

endmodule

`default_nettype wire

//--- bench/motor_model.sv
`timescale 1ns/10ps
`default_nettype none

// Far-side motor: back-EMF crossings, direction and speed
module motor_model (
  // Clock
  input wire logic clk,
  // Bench controls
  input wire logic spin,
  input wire logic backward,
  input wire logic [11:0] speed,
  // Observations toward the device
  output logic zeroCross = 1'b0,
  output logic wrongDirection = 1'b0,
  output logic [11:0] speedDhz = 12'h000
);
  // ==========================================================
  // Rotor behaviour
  // ==========================================================
  logic [3:0] phase_r = 4'h0; // Electrical phase counter

  // One crossing every 16 cycles; a stopped rotor shows none
  // and reports zero speed, so stale readings cannot linger
  always @(posedge clk)
  begin
    phase_r <= phase_r + 4'h1;
    zeroCross <= spin && (phase_r == 4'hF);
    wrongDirection <= spin && backward;
    speedDhz <= spin ? speed : 12'h000;
  end
endmodule

`default_nettype wire

//--- bench/tb_motor_startup_brake_config.sv
`timescale 1ns/10ps
`default_nettype none

module tb_motor_startup_brake_config;
  import motor_startup_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  localparam int CPM = 4; // Short ms keeps timers brief
  logic clk, reset_n, regWrite, regRead, startReq, brakeReq;
  logic [7:0] regAddr;
  logic [15:0] regWriteData, regReadData, rv, c3, c4;
  logic zeroCross, wrongDirection, spin, backward;
  logic [11:0] speedDhz, speed, handoverDhz;
  logic isdActive, motorStationary, reverseStart, alignActive;
  logic alignDone, brakeActive, brakeDone, handoverValid;
  logic [5:0] brakeCurrentMa, hysteresisMv;
  logic [10:0] openLoopCurrentMa, alignCurrentMa;
  logic [12:0] rampRateMvcc;
  logic [19:0] accel2Value;
  logic [16:0] accel1Value;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0; // Edge counter
  int lastZc = 0; // Edge of the latest crossing
  int n;
  time t0; // Start of a timed sequence

  motor_startup_brake_config #(.CYCLES_PER_MS(CPM)) DUT (.clk, .reset_n,
    .regAddr, .regWrite, .regWriteData, .regRead, .regReadData, .startReq,
    .brakeReq, .zeroCross, .wrongDirection, .speedDhz, .isdActive,
    .motorStationary, .reverseStart, .alignActive, .alignDone,
    .brakeActive, .brakeDone, .brakeCurrentMa, .hysteresisMv,
    .openLoopCurrentMa, .alignCurrentMa, .rampRateMvcc, .accel2Value,
    .accel1Value, .handoverDhz, .handoverValid);

  motor_model MOTOR (.clk, .spin, .backward, .speed, .zeroCross,
    .wrongDirection, .speedDhz);

  // ==========================================================
  // Clock and bookkeeping
  // ==========================================================
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Remember when the rotor last crossed zero
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (zeroCross === 1'b1)
      lastZc <= cyc;
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s %0h not %0h", $time, what, got, exp);
    end
  endtask

  // Durations may land up to two edges early or late through the sync stages
  task automatic chkn(input int got, exp, input string what);
    cmp_count++;
    if (got < exp - 2 || got > exp + 2)
    begin
      num_errors++;
      $display("unexpected at %0t: %s %0d not %0d", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    #1 d = regReadData;
  endtask

  // Pulse a start or brake request for one cycle
  task automatic go(input logic brk);
    @(posedge clk);
    startReq <= !brk;
    brakeReq <= brk;
    @(posedge clk);
    startReq <= 1'b0;
    brakeReq <= 1'b0;
    t0 = $time;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: sig = alignDone;
      1: sig = motorStationary;
      2: sig = reverseStart;
      3: sig = brakeActive;
      default: sig = brakeDone;
    endcase
  endfunction

  // Bounded wait for a status signal; returns edges waited
  task automatic waitsig(input int k, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk);
      #1 cnt++;
    end
    while (sig(k) !== 1'b1 && cnt < 20000);
    chk(cnt < 20000, 1'b1, "wait limit");
  endtask

  function automatic int since();
    since = int'(($time - 1 - t0) / 4);
  endfunction

  task automatic chkdec(input logic [15:0] a, b);
    logic [11:0] h;
    h = b[7] ? 12'(128 * b[6:3] + 119) : 12'(8 * b[6:3]);
    chk(brakeCurrentMa, a[13] ? 48 : 24, "brake cur");
    chk(hysteresisMv, a[12] ? 40 : 20, "hyst");
    chk(openLoopCurrentMa, 200 << a[7:6], "open cur");
    chk(alignCurrentMa, 150 << a[7:6], "align cur");
    chk(rampRateMvcc, RAMP_MVCC[a[5:3]], "ramp");
    chk(accel2Value, b[14] ? ACCEL2_SLOW[b[13:11]] :
      ACCEL2_FAST[b[13:11]], "accel2");
    chk(accel2Value == 0, b[13:11] == 3'h7, "accel2 zero");
    chk(accel1Value, b[14] ? ACCEL1_SLOW[b[10:8]] :
      ACCEL1_FAST[b[10:8]], "accel1");
    chk(handoverDhz, h, "handover");
    chk(handoverValid, b[7:3] != 0, "handover ok");
  endtask

  task automatic results();
    $display("tests done: %0d compares, %0d errors", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Watchdog: all tests need well under 30000 cycles
  // ==========================================================
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    {reset_n, regWrite, regRead, startReq, brakeReq} = 5'h00;
    {spin, backward} = 2'h0;
    regAddr = 8'h00;
    regWriteData = 16'h0000;
    speed = 12'h000;
    n = $urandom(62);
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset state of both registers and decoded settings
    rd(8'h92, rv);
    chk(rv, 16'h0000, "reset brake reg");
    rd(8'h93, rv);
    chk(rv, 16'h0000, "reset accel reg");
    chkdec(16'h0000, 16'h0000);
    $display("test reset done");
    // Random readback with the reserved bit written as zero; holes ignored
    repeat (6)
    begin
      c3 = 16'($urandom);
      c4 = 16'($urandom) & 16'h7FFF;
      wr(8'h92, c3);
      wr(8'h93, c4);
      rd(8'h92, rv);
      chk(rv, c3, "brake reg");
      rd(8'h93, rv);
      chk(rv, c4 & 16'h7FFF, "accel reg");
    end
    wr(8'h94, 16'hFFFF);
    rd(8'h94, rv);
    chk(rv, 16'h0000, "unmapped");
    rd(8'h92, rv);
    chk(rv, c3, "after unmapped");
    $display("test registers done");
    // Every code of the 3-bit fields except align time (codes 5 to 7 only), detection off
    for (int i = 0; i < 8; i++)
    begin
      c3 = (16'($urandom) & 16'hF3C0) | 16'(i << 3) | 16'(i);
      c4 = (16'($urandom) & 16'h40F8) | 16'(i << 11) | 16'(i << 8);
      c4 = c4 | 16'(5 + i % 3);
      if (i < 2)
        c4[7:3] = 5'(i << 4); // Unusable code and high range base
      wr(8'h92, c3);
      wr(8'h93, c4);
      go(1'b0);
      @(posedge clk);
      #1 chk(isdActive, 1'b0, "no detect");
      chk(alignActive, 1'b1, "align on");
      @(posedge clk);
      #1 chkdec(c3, c4);
      wr(8'h92, ~c3);
      go(1'b0);
      #1 chkdec(c3, c4);
      waitsig(0, n);
      chkn(since() + 6, (160 >> (i % 3)) * CPM, "align");
    end
    $display("test decode done");
    // Stationary window per code after the rotor stops
    for (int w = 0; w < 4; w++)
    begin
      wr(8'h92, 16'(w << 14) | 16'h0800);
      wr(8'h93, 16'h0007);
      spin <= 1'b1;
      go(1'b0);
      @(posedge clk);
      #1 chk(isdActive, 1'b1, "detect on");
      repeat (60) @(posedge clk);
      spin <= 1'b0;
      waitsig(1, n);
      chkn(cyc - lastZc, (80 << w) * CPM, "window");
      chk(alignActive, 1'b1, "align after");
      waitsig(0, n);
    end
    $display("test detect done");
    // Reverse drive only once speed falls to each threshold
    for (int t = 0; t < 4; t++)
    begin
      c3 = 16'h0C00 | 16'(t << 8);
      speed = 12'(t == 0 ? 63 : t == 1 ? 130 : t == 2 ? 260 : 510);
      wr(8'h92, c3);
      backward <= 1'b1;
      speed <= speed + 12'h001;
      spin <= 1'b1;
      go(1'b0);
      repeat (100) @(posedge clk);
      #1 chk(isdActive, 1'b1, "above thr");
      speed <= speed - 12'h001;
      waitsig(2, n);
      chk(n < 20, 1'b1, "reverse");
    end
    // Reverse disabled: braking takes over, then times out
    // Speed must sit at the code-zero threshold or detection never ends
    speed <= 12'h03F;
    wr(8'h92, 16'h0807);
    go(1'b0);
    waitsig(3, n);
    chk(n < 20, 1'b1, "brake instead");
    t0 = $time;
    spin <= 1'b0;
    waitsig(4, n);
    chkn(since(), 40 * CPM, "brake time");
    $display("test reverse done");
    // Brake request: code zero refused, code six timed
    wr(8'h92, 16'h0000);
    go(1'b1);
    repeat (3) @(posedge clk);
    #1 chk(brakeActive, 1'b0, "brake off");
    wr(8'h92, 16'h0006);
    go(1'b1);
    waitsig(4, n);
    chkn(since(), 80 * CPM, "brake six");
    $display("test brake done");
    results();
  end
endmodule

`default_nettype wire
